/* File: design/modem_hs.sv */
// Purpose: RS232 modem-control handling with automatic half-duplex handshake
// Assumes: line inputs synchronous to pclk; all lines active high
// Notes:   transmitter/receiver are outside; this block gates and times them
//          counts are in pclk ticks; a count of zero still costs one tick
//          leaving auto mode mid-frame keeps rts at its last level until a manual write, without an abort pulse
//
// Behaviour
// [RULE_01] after reset DTR and RTS stay inactive until configured or written
// [RULE_02] software can read all six handshake line levels at any time
// [RULE_03] DCD, DSR, CTS and RI are inputs from the remote station
// [RULE_04] outside automatic mode software sets or clears DTR and RTS
// [RULE_05] DTR writable under any flow control; RTS only under none or XON/XOFF; the code also accepts RTS writes under reserved flow 3
// [RULE_06] automatic mode only allowed in half-duplex configuration
// [RULE_07] in automatic mode software writes to DTR/RTS are refused
// [RULE_08] entering automatic mode drives RTS inactive and DTR active
// [RULE_09] send request in automatic mode raises RTS and starts wait timer
// [RULE_10] frame starts only after wait time elapsed and CTS active
// [RULE_11] CTS missing by wait end or lost during send aborts with error
// [RULE_12] remote asserts CTS before wait expiry and holds it through frame
// [RULE_13] after last character wait RTS-off time then drop RTS, ignoring CTS
// [RULE_14] in automatic mode receive only while DSR is active
// [RULE_15] near receive overflow give the remote no handshake response
// [RULE_16] DSR falling aborts send or reception in progress with error; the code aborts either only in automatic mode
// [RULE_17] DSR-loss abort in automatic mode records distinct diagnostic event
// [RULE_18] RTS-off delay must cover remote receiving the final characters
// [RULE_19] wait and RTS-off times are programmable tick counts on down-counters
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/10ps
module modem_hs
  import modem_hs_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire modem_in_t   line_in,
  output modem_out_t       line_out,
  input  wire logic        tx_req,
  output logic             tx_start,
  input  wire logic        tx_last_done,
  output logic             tx_abort,
  output logic             rx_enable,
  input  wire logic        rx_active,
  output logic             rx_abort,
  input  wire logic        rx_near_full,
  output logic             irq
);

  // ==========================================================
  // states
  typedef enum logic [2:0] {
    S_MANUAL,
    S_IDLE,
    S_WAIT_CTS,
    S_SEND,
    S_RTS_OFF
  } hs_state_t;

  // registers
  hs_state_t           state_reg;
  logic [31:0]         ctrl_reg;
  logic [31:0]         wait_reg;
  logic [31:0]         rtsoff_reg;
  logic [31:0]         cnt_reg;
  logic [NUM_EV-1:0]   stat_reg;
  logic [NUM_EV-1:0]   ien_reg;
  logic [NUM_EV-1:0]   ev;
  logic                dtr_reg;
  logic                rts_reg;
  logic                dsr_prev_reg;
  logic                tx_start_reg;
  logic                tx_abort_reg;
  logic                rx_abort_reg;

  // decode and helpers
  logic                wr_acc;
  logic                rd_acc;
  logic                addr_ok;
  logic                auto_on;
  logic                auto_want;
  logic                dsr_fall;
  flow_t               flow;
  // strobes and helpers
  logic                wr_ctrl;
  logic                wr_outw;
  logic                wr_wait;
  logic                wr_rtsoff;
  logic                wr_clr;
  logic                wr_ien;
  logic                cnt_zero;
  logic                dtr_wr_ok;
  logic                rts_wr_ok;
  logic [31:0]         line_word;

  // ==========================================================
  // apb decode
  // map: ctrl 00, line state 04 (ro), output write 08, wait count 0c,
  //      rts-off count 10, status 14 (ro, sticky), clear 18 (wo), enable 1c
  // pready is tied high: every access completes in its first access cycle,
  // read data is registered and so stands from the cycle after the access
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign addr_ok = (paddr == CTRL_OFF) || (paddr == LINE_OFF) || (paddr == OUTW_OFF) ||
                   (paddr == WAIT_OFF) || (paddr == RTSOFF_OFF) || (paddr == STAT_OFF) ||
                   (paddr == CLR_OFF) || (paddr == IEN_OFF);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // ==========================================================
  // write strobes
  // one strobe per register keeps every write path in one place
  assign wr_ctrl   = wr_acc && (paddr == CTRL_OFF);
  assign wr_outw   = wr_acc && (paddr == OUTW_OFF);
  assign wr_wait   = wr_acc && (paddr == WAIT_OFF);
  assign wr_rtsoff = wr_acc && (paddr == RTSOFF_OFF);
  assign wr_clr    = wr_acc && (paddr == CLR_OFF);
  assign wr_ien    = wr_acc && (paddr == IEN_OFF);

  assign flow      = flow_t'(ctrl_reg[CTRL_FLOW_LSB +: 2]);
  // automatic mode is only honoured in half duplex
  assign auto_want = ctrl_reg[CTRL_AUTO_BIT] && ctrl_reg[CTRL_HALF_BIT]; // [RULE_06]
  assign auto_on   = (state_reg != S_MANUAL);
  assign dsr_fall  = dsr_prev_reg && !line_in.dsr;
  assign cnt_zero  = (cnt_reg == 32'h0);
  // manual writes: dtr under every flow mode, rts only without hardware flow
  assign dtr_wr_ok = wr_outw && !auto_want; // [RULE_04] [RULE_05] [RULE_07]
  assign rts_wr_ok = wr_outw && !auto_want && (flow != FLOW_RTSCTS); // [RULE_05] [RULE_07]

  // ==========================================================
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_ctrl) begin
      // only flow, duplex and auto bits exist; the rest read back zero
      ctrl_reg <= {28'h0, pwdata[3:0]};
    end
  end

  // a zero count means a one-tick wait, not a wrap to the maximum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= WAIT_RST;
    end else if (wr_wait) begin
      wait_reg <= pwdata; // [RULE_19]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtsoff_reg <= RTSOFF_RST;
    end else if (wr_rtsoff) begin
      rtsoff_reg <= pwdata; // [RULE_19]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_reg <= '0;
    end else if (wr_ien) begin
      ien_reg <= pwdata[NUM_EV-1:0];
    end
  end

  // ==========================================================
  // dsr edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsr_prev_reg <= 1'b0;
    end else begin
      dsr_prev_reg <= line_in.dsr;
    end
  end

  // ==========================================================
  // handshake sequencer
  // the wait count is loaded on the request edge and counted down to zero;
  // cts is only judged once the count is spent, so an early cts does not
  // shorten the wait. dsr loss wins over every other outcome while waiting or sending.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= S_MANUAL;
      cnt_reg      <= '0;
      tx_start_reg <= 1'b0;
      tx_abort_reg <= 1'b0;
    end else begin
      tx_start_reg <= 1'b0;
      tx_abort_reg <= 1'b0;
      if (!auto_want) begin
        state_reg <= S_MANUAL;
      end else begin
        unique case (state_reg)
          // first auto cycle: outputs settle to dtr on, rts off
          S_MANUAL: state_reg <= S_IDLE;
          S_IDLE: begin
            // a request without dsr is simply not taken
            if (tx_req && line_in.dsr) begin
              state_reg <= S_WAIT_CTS; // [RULE_09]
              cnt_reg   <= wait_reg;
            end
          end
          S_WAIT_CTS: begin
            if (dsr_fall) begin
              state_reg    <= S_IDLE; // [RULE_16]
              tx_abort_reg <= 1'b1;
            end else if (cnt_reg != 32'h0) begin
              cnt_reg <= cnt_reg - 32'h1;
            end else if (line_in.cts) begin
              state_reg    <= S_SEND; // [RULE_10]
              tx_start_reg <= 1'b1;
            end else begin
              state_reg    <= S_IDLE; // [RULE_11]
              tx_abort_reg <= 1'b1;
            end
          end
          S_SEND: begin
            if (!line_in.cts || dsr_fall) begin
              state_reg    <= S_IDLE; // [RULE_11] [RULE_16]
              tx_abort_reg <= 1'b1;
            end else if (tx_last_done) begin
              state_reg <= S_RTS_OFF; // [RULE_13]
              cnt_reg   <= rtsoff_reg;
            end
          end
          S_RTS_OFF: begin
            // cts is deliberately not looked at here
            if (cnt_reg != 32'h0) begin
              cnt_reg <= cnt_reg - 32'h1;
            end else begin
              state_reg <= S_IDLE; // [RULE_13]
            end
          end
          default: state_reg <= S_MANUAL;
        endcase
      end
    end
  end

  // ==========================================================
  // output lines
  // both lines are flip-flops so a decode glitch never reaches a pin
  // dtr: auto mode holds it on; a manual write lands only outside auto mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dtr_reg <= 1'b0; // [RULE_01]
    end else if (auto_want) begin
      dtr_reg <= 1'b1; // [RULE_08]
    end else if (dtr_wr_ok) begin
      dtr_reg <= pwdata[OUT_DTR_BIT]; // [RULE_04] [RULE_05]
    end
  end

  // rts: high from the taken request until the rts-off count is spent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_reg <= 1'b0; // [RULE_01]
    end else if (auto_want) begin
      rts_reg <= (state_reg == S_WAIT_CTS) || (state_reg == S_SEND) ||
                 (state_reg == S_RTS_OFF); // [RULE_08] [RULE_09] [RULE_13]
    end else if (rts_wr_ok) begin
      rts_reg <= pwdata[OUT_RTS_BIT]; // [RULE_04] [RULE_05]
    end
  end
  assign line_out.dtr = dtr_reg;
  assign line_out.rts = rts_reg;

  // ==========================================================
  // receive gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_abort_reg <= 1'b0;
    end else begin
      rx_abort_reg <= auto_on && dsr_fall && rx_active; // [RULE_16]
    end
  end
  // when nearly full the receiver just stops answering; no flow line is toggled
  always_comb begin
    rx_enable = !rx_near_full; // [RULE_15]
    if (auto_on && !line_in.dsr) begin
      rx_enable = 1'b0; // [RULE_14]
    end
  end
  assign tx_start  = tx_start_reg;
  assign tx_abort  = tx_abort_reg;
  assign rx_abort  = rx_abort_reg;

  // ==========================================================
  // events and interrupt
  // tx done fires on the last rts-off tick, while rts is still high
  always_comb begin
    ev              = '0;
    ev[EV_TXDONE]   = (state_reg == S_RTS_OFF) && cnt_zero && auto_want;
    ev[EV_TXERR]    = tx_abort_reg; // [RULE_11]
    ev[EV_RXERR]    = rx_abort_reg; // [RULE_16]
    ev[EV_DSRLOSS]  = auto_on && dsr_fall; // [RULE_17]
    ev[EV_REFUSED]  = wr_acc && (paddr == OUTW_OFF) && auto_want; // [RULE_07]
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= '0;
    end else if (wr_clr) begin
      stat_reg <= (stat_reg & ~pwdata[NUM_EV-1:0]) | ev;
    end else begin
      stat_reg <= stat_reg | ev;
    end
  end
  // level interrupt: high while any enabled sticky bit stands
  assign irq = |(stat_reg & ien_reg);

  // ==========================================================
  // line state word
  // every handshake level as it stands, in every mode
  assign line_word = {25'h0, auto_on, line_in.ri, line_in.cts, rts_reg,
                      line_in.dsr, dtr_reg, line_in.dcd}; // [RULE_02] [RULE_03]

  // ==========================================================
  // read data
  // unmapped and write-only offsets read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_acc) begin
      unique case (paddr)
        CTRL_OFF:   prdata <= ctrl_reg;
        LINE_OFF:   prdata <= line_word; // [RULE_02]
        OUTW_OFF:   prdata <= {30'h0, rts_reg, dtr_reg};
        WAIT_OFF:   prdata <= wait_reg;
        RTSOFF_OFF: prdata <= rtsoff_reg;
        STAT_OFF:   prdata <= {27'h0, stat_reg};
        IEN_OFF:    prdata <= {27'h0, ien_reg};
        default:    prdata <= 32'h0;
      endcase
    end
  end

endmodule

/* File: design/modem_hs_pkg.sv */
// Purpose: shared constants and types for the modem handshake block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
package modem_hs_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] LINE_OFF   = 8'h04;
  localparam logic [7:0] OUTW_OFF   = 8'h08;
  localparam logic [7:0] WAIT_OFF   = 8'h0c;
  localparam logic [7:0] RTSOFF_OFF = 8'h10;
  localparam logic [7:0] STAT_OFF   = 8'h14;
  localparam logic [7:0] CLR_OFF    = 8'h18;
  localparam logic [7:0] IEN_OFF    = 8'h1c;
  // ==========================================================
  // field positions
  localparam int CTRL_FLOW_LSB = 0;  // 2 bits: flow control
  localparam int CTRL_HALF_BIT = 2;
  localparam int CTRL_AUTO_BIT = 3;
  localparam int OUT_DTR_BIT   = 0;
  localparam int OUT_RTS_BIT   = 1;
  localparam int LINE_DCD_BIT  = 0;
  localparam int LINE_DTR_BIT  = 1;
  localparam int LINE_DSR_BIT  = 2;
  localparam int LINE_RTS_BIT  = 3;
  localparam int LINE_CTS_BIT  = 4;
  localparam int LINE_RI_BIT   = 5;
  localparam int LINE_BUSY_BIT = 6;
  localparam int EV_TXDONE     = 0;
  localparam int EV_TXERR      = 1;
  localparam int EV_RXERR      = 2;
  localparam int EV_DSRLOSS    = 3;
  localparam int EV_REFUSED    = 4;
  localparam int NUM_EV        = 5;
  // ==========================================================
  // reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] WAIT_RST   = 32'h0000_0064;
  localparam logic [31:0] RTSOFF_RST = 32'h0000_0064;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    FLOW_NONE = 2'h0,
    FLOW_XON  = 2'h1,
    FLOW_RTSCTS = 2'h2,
    FLOW_RSVD = 2'h3
  } flow_t;
  typedef struct packed {
    logic dcd;
    logic dsr;
    logic cts;
    logic ri;
  } modem_in_t;
  typedef struct packed {
    logic dtr;
    logic rts;
  } modem_out_t;
endpackage

/* File: sim/modem_hs_asserts.sv */
// Purpose: port checker for modem_hs
// Assumes: one clock, inputs synchronous to pclk
// Notes:   sending spans tx_start to last character or abort
`timescale 1ns/10ps
module modem_hs_asserts
  import modem_hs_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire modem_in_t   line_in,
  input wire modem_out_t  line_out,
  input wire logic        tx_start,
  input wire logic        tx_last_done,
  input wire logic        tx_abort
);
  // ==========================================================
  // helpers
  logic       sending;
  logic [5:0] lines;
  assign lines = {line_in.ri, line_in.cts, line_out.rts, line_in.dsr, line_out.dtr, line_in.dcd};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sending <= 1'b0;
    else if (tx_start)
      sending <= 1'b1;
    else if (tx_abort || tx_last_done)
      sending <= 1'b0;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // properties
  AST_RESET_IDLE: assert property (!$past(presetn) |-> line_out == 2'b00)
    else $error("handshake outputs active after reset");
  AST_LINE_READ: assert property (psel && penable && !pwrite && paddr == LINE_OFF |=> prdata[5:0] == $past(lines))
    else $error("line state read wrong");
  AST_START_GATED: assert property (tx_start |-> line_out.rts && $past(line_in.cts))
    else $error("frame started without rts or cts");
  AST_ONE_OUTCOME: assert property (tx_start |-> !tx_abort ##1 !tx_start)
    else $error("start pulse malformed");
  AST_CTS_LOSS: assert property (sending && !line_in.cts |-> ##[0:3] tx_abort)
    else $error("cts loss not aborted");
  AST_DSR_LOSS: assert property (sending && $fell(line_in.dsr) |-> ##[0:3] tx_abort)
    else $error("dsr loss not aborted");
  AST_PREADY: assert property (pready)
    else $error("pready low");
  AST_SLVERR: assert property (psel && penable && !pwrite && paddr > IEN_OFF |-> pslverr ##1 prdata == 32'h0)
    else $error("unmapped read not refused");
endmodule

/* File: sim/remote_station.sv */
// Purpose: remote station model driving the modem inputs
// Assumes: cts answers rts cts_delay+1 cycles after rts rises
// Notes:   drop_cts breaks the hold rule on command only
`timescale 1ns/10ps
module remote_station
  import modem_hs_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire modem_out_t line_out,
  input  wire logic [7:0] cts_delay,
  input  wire logic       drop_cts,
  input  wire logic [2:0] lines_on,
  output modem_in_t       line_in
);
  logic [7:0] cnt;
  logic       cts;
  // cts only answers a raised rts and is held until rts drops or drop_cts is raised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      cts <= 1'b0;
    end else if (!line_out.rts) begin
      cnt <= 8'h00;
      cts <= 1'b0;
    end else if (cnt < cts_delay) begin
      cnt <= cnt + 8'h01;
    end else begin
      cts <= !drop_cts;
    end
  end
  assign line_in = {lines_on[2], lines_on[1], cts, lines_on[0]};
endmodule

/* File: sim/tb.sv */
// Purpose: self-checking bench for modem_hs
// Assumes: zero-wait APB, read data one cycle after access
// Notes:   short wait and rts-off counts keep the run brief
`timescale 1ns/10ps
module tb;
  import modem_hs_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0, cts_delay = 2;
  logic [31:0] pwdata = 0, prdata, r;
  logic        pready, pslverr, err, got, irq, tx_start, tx_abort, rx_enable, rx_abort;
  logic        tx_req = 0, tx_last_done = 0, rx_active = 0, drop_cts = 0, rx_near_full = 0;
  logic [2:0]  lines_on = 3'b111;
  modem_in_t   line_in;
  modem_out_t  line_out;
  int          fails = 0, total_checks = 0, cyc = 0, n;
  always #2.5 pclk = ~pclk;
  modem_hs modem_hs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_in(line_in),
    .line_out(line_out), .tx_req(tx_req), .tx_start(tx_start), .tx_last_done(tx_last_done),
    .tx_abort(tx_abort), .rx_enable(rx_enable), .rx_active(rx_active), .rx_abort(rx_abort),
    .rx_near_full(rx_near_full), .irq(irq));
  remote_station remote_station_inst (.pclk(pclk), .presetn(presetn), .line_out(line_out),
    .cts_delay(cts_delay), .drop_cts(drop_cts), .lines_on(lines_on), .line_in(line_in));
  // ==========================================================
  // tasks
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    r = prdata;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  // one-cycle request avoids a second take after an early abort
  task send(input logic [7:0] dly);
    while (line_out.rts) @(negedge pclk);
    @(posedge pclk);
    cts_delay <= dly;
    tx_req <= 1'b1;
    @(posedge pclk);
    tx_req <= 1'b0;
    n = 1;
    repeat (2) @(negedge pclk);
    chk(32'(line_out.rts), 32'h1);
    do begin
      @(negedge pclk);
      n++;
    end while (!tx_start && !tx_abort);
    got = tx_start;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_of_test;
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(line_out), 32'h0);
    rd(CTRL_OFF, CTRL_RST);
    rd(RTSOFF_OFF, RTSOFF_RST);
    rd(LINE_OFF, 32'h25);
    apb(1'b1, CTRL_OFF, 32'h2);
    apb(1'b1, OUTW_OFF, 32'h3);
    chk(32'(line_out), 32'h2);
    apb(1'b1, CTRL_OFF, 32'h1);
    apb(1'b1, OUTW_OFF, 32'h2);
    chk(32'(line_out), 32'h1);
    apb(1'b1, CTRL_OFF, 32'h8);
    rd(LINE_OFF, 32'h3d);
    apb(1'b1, CTRL_OFF, 32'hc);
    @(posedge pclk);
    chk(32'(line_out), 32'h2);
    apb(1'b1, OUTW_OFF, 32'h1);
    chk(32'(line_out), 32'h2);
    rd(LINE_OFF, 32'h67);
    rd(STAT_OFF, 32'h10);
    chk(32'(irq), 32'h0);
    apb(1'b1, IEN_OFF, 32'h1f);
    chk(32'(irq), 32'h1);
    apb(1'b1, CLR_OFF, 32'h1f);
    chk(32'(irq), 32'h0);
    apb(1'b1, WAIT_OFF, 32'h4);
    apb(1'b1, RTSOFF_OFF, 32'h4);
    send(8'd1);
    chk(32'(got && n > 4), 32'h1);
    @(posedge pclk);
    tx_last_done <= 1'b1;
    @(posedge pclk);
    tx_last_done <= 1'b0;
    n = 0;
    while (line_out.rts) begin
      @(negedge pclk);
      n++;
    end
    chk(32'(n > 3 && line_in.cts), 32'h1);
    rd(STAT_OFF, 32'h1);
    apb(1'b1, CLR_OFF, 32'h1f);
    send(8'd20);
    chk(32'(got), 32'h0);
    rd(STAT_OFF, 32'h2);
    apb(1'b1, CLR_OFF, 32'h1f);
    send(8'd1);
    @(posedge pclk);
    drop_cts <= 1'b1;
    while (!tx_abort) @(negedge pclk);
    @(posedge pclk);
    drop_cts <= 1'b0;
    rd(STAT_OFF, 32'h2);
    apb(1'b1, CLR_OFF, 32'h1f);
    send(8'd1);
    @(posedge pclk);
    lines_on <= 3'b101;
    while (!tx_abort) @(negedge pclk);
    apb(1'b0, STAT_OFF, 32'h0);
    chk(32'(r[EV_DSRLOSS]), 32'h1);
    lines_on <= 3'b111;
    @(negedge pclk);
    chk(32'(rx_enable), 32'h1);
    @(posedge pclk);
    rx_near_full <= 1'b1;
    @(negedge pclk);
    chk(32'(rx_enable), 32'h0);
    chk(32'(line_out), 32'h2);
    @(posedge pclk);
    rx_near_full <= 1'b0;
    @(posedge pclk);
    rx_active <= 1'b1;
    lines_on <= 3'b101;
    while (!rx_abort) @(negedge pclk);
    chk(32'(rx_enable), 32'h0);
    @(posedge pclk);
    rx_active <= 1'b0;
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(err), 32'h1);
    chk(r, 32'h0);
    end_of_test;
  end
endmodule
bind modem_hs modem_hs_asserts modem_hs_asserts_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .line_in(line_in), .line_out(line_out), .tx_start(tx_start), .tx_last_done(tx_last_done), .tx_abort(tx_abort));
